// ===== sebs_device.sv
// Memory end of the two-wire link: select decode, acks, reads, writes.
// Assumes the master clocks the link; all pins are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
module sebs_device
    import sebs_pkg::*;
#(
    parameter sebs_variant_t VARIANT    = VAR_16K,
    parameter int unsigned   PROG_CYC_P = PROG_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    sebs_link_if.dev        link,
    input  wire logic [2:0] chip_select_pins_i,
    input  wire logic       write_inhibit_pin_i,
    input  wire logic       supply_reset_i,
    output logic            prog_busy_o
);
    // Pins compared against select bits b3..b1, per variant
    localparam logic [2:0] CS_MASK =
        (VARIANT == VAR_1K || VARIANT == VAR_2K) ? 3'h7 :
        (VARIANT == VAR_4K) ? 3'h6 :
        (VARIANT == VAR_8K) ? 3'h4 : 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_MASK =
        (VARIANT == VAR_1K) ? 11'h07F :
        (VARIANT == VAR_2K) ? 11'h0FF :
        (VARIANT == VAR_4K) ? 11'h1FF :
        (VARIANT == VAR_8K) ? 11'h3FF : 11'h7FF;
    localparam logic [PROG_W-1:0] PROG_LOAD = PROG_W'(PROG_CYC_P - 1);

    logic [7:0]        mem [MEM_BYTES];
    logic [6:0]        sync1_q;
    logic [6:0]        sync2_q;
    logic              scl_prev_q;
    logic              sda_prev_q;
    logic              scl;
    logic              sda;
    logic [2:0]        cs_pins;
    logic              inhibit;
    logic              supply_rst;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_seen;
    logic              stop_seen;
    logic              sel_match;
    logic [7:0]        rd_byte;
    logic              mem_we;
    sebs_dev_state_t   st_q;
    sebs_dev_state_t   st_d;
    logic [3:0]        bit_q;
    logic [3:0]        bit_d;
    logic [7:0]        sh_q;
    logic [7:0]        sh_d;
    logic [ADDR_W-1:0] ptr_q;
    logic [ADDR_W-1:0] ptr_d;
    logic              oe_q;
    logic              oe_d;
    logic              mack_q;
    logic              mack_d;
    logic              wrote_q;
    logic              wrote_d;
    logic [PROG_W-1:0] prog_q;
    logic [PROG_W-1:0] prog_d;
    logic              busy_q;
    logic              busy_d;
    logic              low_q;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 7'h7E;
            sync2_q <= 7'h7E;
        end else begin
            sync1_q <= {link.scl, link.sda, chip_select_pins_i,
                        write_inhibit_pin_i, supply_reset_i};
            sync2_q <= sync1_q;
        end
    end

    assign scl        = sync2_q[6];
    assign sda        = sync2_q[5];
    assign cs_pins    = sync2_q[4:2];
    assign inhibit    = sync2_q[1];
    assign supply_rst = sync2_q[0];

    assign scl_rise   = scl & ~scl_prev_q;
    assign scl_fall   = ~scl & scl_prev_q;
    assign start_seen = scl & scl_prev_q & ~sda & sda_prev_q;
    assign stop_seen  = scl & scl_prev_q & sda & ~sda_prev_q;

    // Live pin levels are used at every compare
    assign sel_match = (sh_q[7:4] == SEL_TYPE_CODE) &&
        ((sh_q[3:1] & CS_MASK) == (cs_pins & CS_MASK));

    // Asynchronous read keeps the next byte ready at each ack edge
    assign rd_byte = mem[ptr_q & ADDR_MASK];

    always_comb begin
        st_d    = st_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        oe_d    = oe_q;
        mack_d  = mack_q;
        wrote_d = wrote_q;
        prog_d  = prog_q;
        mem_we  = 1'b0;
        if (supply_rst) begin
            st_d  = DS_IDLE;
            oe_d  = 1'b0;
            bit_d = 4'h0;
        end else if (st_q == DS_PROG) begin
            if (prog_q == '0) begin
                st_d = DS_IDLE;
            end else begin
                prog_d = prog_q - 1'b1;
            end
        end else if (start_seen) begin
            st_d  = DS_DSEL;
            // The clock fall that ends a start comes before bit 0
            bit_d = 4'hF;
            oe_d  = 1'b0;
        end else if (stop_seen) begin
            oe_d = 1'b0;
            if (wrote_q) begin
                st_d    = DS_PROG;
                prog_d  = PROG_LOAD;
                wrote_d = 1'b0;
            end else begin
                st_d = DS_IDLE;
            end
        end else if (st_q != DS_IDLE) begin
            if (scl_rise && bit_q < ACK_BIT && st_q != DS_RDATA) begin
                sh_d = {sh_q[6:0], sda};
            end
            if (scl_rise && bit_q == ACK_BIT && st_q == DS_RDATA) begin
                mack_d = ~sda;
            end
            if (scl_fall) begin
                if (bit_q == ACK_BIT) begin
                    oe_d  = 1'b0;
                    bit_d = 4'h0;
                    case (st_q)
                        DS_DSEL: begin
                            if (sh_q[SEL_RNW_BIT]) begin
                                st_d = DS_RDATA;
                                sh_d = rd_byte;
                                oe_d = ~rd_byte[7];
                            end else begin
                                st_d = DS_ADDR;
                            end
                        end
                        DS_ADDR: begin
                            st_d = DS_WDATA;
                        end
                        DS_RDATA: begin
                            if (mack_q) begin
                                sh_d = rd_byte;
                                oe_d = ~rd_byte[7];
                            end else begin
                                st_d = DS_IDLE;
                            end
                        end
                        default: begin
                            st_d = st_q;
                        end
                    endcase
                end else if (bit_q == LAST_BIT) begin
                    bit_d = ACK_BIT;
                    case (st_q)
                        DS_DSEL: begin
                            if (sel_match) begin
                                oe_d = 1'b1;
                                ptr_d[ADDR_W-1:8] =
                                    sh_q[3:1] & ~CS_MASK;
                            end else begin
                                st_d = DS_IDLE;
                            end
                        end
                        DS_ADDR: begin
                            oe_d       = 1'b1;
                            ptr_d[7:0] = sh_q;
                        end
                        DS_WDATA: begin
                            // A low inhibit pin allows writes anywhere
                            if (!inhibit) begin
                                oe_d    = 1'b1;
                                mem_we  = 1'b1;
                                ptr_d   = ptr_q + 1'b1;
                                wrote_d = 1'b1;
                            end else begin
                                oe_d = 1'b0;
                            end
                        end
                        DS_RDATA: begin
                            oe_d  = 1'b0;
                            ptr_d = ptr_q + 1'b1;
                        end
                        default: begin
                            st_d = st_q;
                        end
                    endcase
                end else begin
                    bit_d = bit_q + 1'b1;
                    if (st_q == DS_RDATA) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
            end
        end
    end

    assign busy_d = (st_d == DS_PROG);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            st_q       <= DS_IDLE;
            bit_q      <= 4'h0;
            sh_q       <= 8'h00;
            ptr_q      <= '0;
            oe_q       <= 1'b0;
            mack_q     <= 1'b0;
            wrote_q    <= 1'b0;
            prog_q     <= '0;
            busy_q     <= 1'b0;
            low_q      <= 1'b0;
        end else begin
            scl_prev_q <= scl;
            sda_prev_q <= sda;
            st_q       <= st_d;
            bit_q      <= bit_d;
            sh_q       <= sh_d;
            ptr_q      <= ptr_d;
            oe_q       <= oe_d;
            mack_q     <= mack_d;
            wrote_q    <= wrote_d;
            prog_q     <= prog_d;
            busy_q     <= busy_d;
            low_q      <= 1'b0;
        end
    end

    // Array has no reset; contents are undefined until written
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[ptr_q & ADDR_MASK] <= sh_q;
        end
    end

    // Open drain: the data level is always low, only the enable moves
    assign link.dev_sda_o  = low_q;
    assign link.dev_sda_oe = oe_q;
    assign prog_busy_o     = busy_q;
endmodule // sebs_device
`default_nettype wire

// ===== sebs_host.sv
// Bus master end: byte-level start, stop, write and read commands.
// Assumes software on a plain register port; read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module sebs_host
    import sebs_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    sebs_link_if.host       link,
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o
);
    localparam logic [QTR_W-1:0] QTR_LOAD = QTR_W'(QTR_CYC - 1);

    sebs_host_state_t st_q;
    sebs_host_state_t st_d;
    logic [QTR_W-1:0] tmr_q;
    logic [QTR_W-1:0] tmr_d;
    logic [1:0]       qtr_q;
    logic [1:0]       qtr_d;
    logic [3:0]       bitn_q;
    logic [3:0]       bitn_d;
    logic [8:0]       out_q;
    logic [8:0]       out_d;
    logic [8:0]       in_q;
    logic [8:0]       in_d;
    logic [7:0]       tx_q;
    logic [7:0]       tx_d;
    logic [7:0]       rx_q;
    logic [7:0]       rx_d;
    logic             ack_q;
    logic             ack_d;
    logic             scl_oe_q;
    logic             scl_oe_d;
    logic             sda_oe_q;
    logic             sda_oe_d;
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic             sda_s1_q;
    logic             sda_s2_q;
    logic             low_q;
    logic             busy;

    assign busy = (st_q != HS_IDLE);

    always_comb begin
        st_d     = st_q;
        tmr_d    = tmr_q;
        qtr_d    = qtr_q;
        bitn_d   = bitn_q;
        out_d    = out_q;
        in_d     = in_q;
        tx_d     = tx_q;
        rx_d     = rx_q;
        ack_d    = ack_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        rdata_d  = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_DATA:   rdata_d = rx_q;
                REG_STATUS: rdata_d = {6'h00, ack_q, busy};
                default:    rdata_d = 8'h00;
            endcase
        end
        // Writes while a command runs are dropped
        if (reg_wr_i && !busy) begin
            tmr_d  = QTR_LOAD;
            qtr_d  = 2'h0;
            bitn_d = 4'h0;
            if (reg_addr_i == REG_DATA) begin
                tx_d = reg_wdata_i;
            end else if (reg_addr_i == REG_CMD) begin
                case (reg_wdata_i[1:0])
                    CMD_START: st_d = HS_START;
                    CMD_STOP:  st_d = HS_STOP;
                    CMD_WRITE: begin
                        st_d  = HS_BYTE;
                        out_d = {tx_q, 1'b1};
                    end
                    default: begin
                        st_d  = HS_BYTE;
                        out_d = {ALL_ONES,
                                 ~reg_wdata_i[CMD_ACK_BIT]};
                    end
                endcase
            end
        end else if (busy) begin
            if (tmr_q != '0) begin
                tmr_d = tmr_q - 1'b1;
            end else begin
                tmr_d = QTR_LOAD;
                qtr_d = qtr_q + 1'b1;
                case (st_q)
                    HS_START: begin
                        // Repeated start: release data before clock
                        case (qtr_q)
                            2'h0:    sda_oe_d = 1'b0;
                            2'h1:    scl_oe_d = 1'b0;
                            2'h2:    sda_oe_d = 1'b1;
                            default: begin
                                scl_oe_d = 1'b1;
                                st_d     = HS_IDLE;
                            end
                        endcase
                    end
                    HS_STOP: begin
                        case (qtr_q)
                            2'h0:    sda_oe_d = 1'b1;
                            2'h1:    scl_oe_d = 1'b0;
                            2'h2:    sda_oe_d = 1'b0;
                            default: st_d = HS_IDLE;
                        endcase
                    end
                    HS_BYTE: begin
                        case (qtr_q)
                            2'h0:    sda_oe_d = ~out_q[8];
                            2'h1:    scl_oe_d = 1'b0;
                            2'h2:    in_d = {in_q[7:0], sda_s2_q};
                            default: begin
                                scl_oe_d = 1'b1;
                                out_d    = {out_q[7:0], 1'b1};
                                bitn_d   = bitn_q + 1'b1;
                                if (bitn_q == ACK_BIT) begin
                                    st_d  = HS_IDLE;
                                    rx_d  = in_q[8:1];
                                    ack_d = ~in_q[0];
                                end
                            end
                        endcase
                    end
                    default: st_d = HS_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q     <= HS_IDLE;
            tmr_q    <= '0;
            qtr_q    <= 2'h0;
            bitn_q   <= 4'h0;
            out_q    <= 9'h1FF;
            in_q     <= 9'h000;
            tx_q     <= 8'h00;
            rx_q     <= 8'h00;
            ack_q    <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rdata_q  <= 8'h00;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            low_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            tmr_q    <= tmr_d;
            qtr_q    <= qtr_d;
            bitn_q   <= bitn_d;
            out_q    <= out_d;
            in_q     <= in_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            ack_q    <= ack_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            rdata_q  <= rdata_d;
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
            low_q    <= 1'b0;
        end
    end

    assign link.host_scl_o  = low_q;
    assign link.host_sda_o  = low_q;
    assign link.host_scl_oe = scl_oe_q;
    assign link.host_sda_oe = sda_oe_q;
    assign reg_rdata_o      = rdata_q;
endmodule // sebs_host
`default_nettype wire

// ===== sebs_link_chk.sv
// Checker for the two-wire link: open-drain use, start/stop, device timing.
// Assumes it sees the wired levels and all enables of both ends.
`timescale 1ns/1ps
`default_nettype none
module sebs_link_chk (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic       frame_q;
    logic [7:0] low_q;
    // Raw lines, not resynchronised: the device lags, so it is never early
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            frame_q <= 1'b0;
            low_q   <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) frame_q <= 1'b1;
            else if (scl && scl_q && !sda_q && sda) frame_q <= 1'b0;
            if (scl) low_q <= 8'h00;
            else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_host_sda_od; !host_sda_o; endproperty
    a_host_sda_od: assert property (p_host_sda_od)
        else $error("host drives data line high");
    property p_host_scl_od; !host_scl_o; endproperty
    a_host_scl_od: assert property (p_host_scl_od)
        else $error("host drives clock line high");
    property p_dev_sda_od; !dev_sda_o; endproperty
    a_dev_sda_od: assert property (p_dev_sda_od)
        else $error("device drives data line high");
    property p_dev_timing; $changed(dev_sda_oe) |-> low_q inside {[2:6]};
    endproperty
    a_dev_timing: assert property (p_dev_timing)
        else $error("device data change not just after clock fall");
    property p_dev_frame; dev_sda_oe |-> frame_q; endproperty
    a_dev_frame: assert property (p_dev_frame)
        else $error("device drives outside a frame");
    property p_start; (scl && scl_q && sda_q && !sda) |-> $rose(host_sda_oe);
    endproperty
    a_start: assert property (p_start)
        else $error("start not made by the host");
    property p_stop; (scl && scl_q && !sda_q && sda) |-> $fell(host_sda_oe);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop not made by the host");
    property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");
endmodule // sebs_link_chk
`default_nettype wire

// ===== sebs_link_if.sv
// Two-wire link between the bus master end and the memory end.
// Assumes pull-ups: a line is low while any enabled driver drives low.
`timescale 1ns/1ps
`default_nettype none
interface sebs_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) |
                   (dev_sda_oe & ~dev_sda_o));

    modport host (
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
        input  scl, sda
    );
    modport dev (
        output dev_sda_o, dev_sda_oe,
        input  scl, sda
    );
endinterface
`default_nettype wire

// ===== sebs_pkg.sv
// Constants, types and encodings shared by both ends of the two-wire link.
// Assumes a 50 MHz reference clock on both ends.
package sebs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SCL_PERIOD_NS = 10000;
    localparam int unsigned QTR_CYC =
        SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int unsigned PROG_TIME_NS = 2000000;
    localparam int unsigned PROG_CYC =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_W = 17;
    localparam int unsigned QTR_W = 8;
    localparam int unsigned MEM_BYTES = 2048;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned PAGE_BYTES = 16;
    // Type code value is arbitrary
    localparam logic [3:0] SEL_TYPE_CODE = 4'h6;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam int unsigned SEL_RNW_BIT = 0;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    typedef enum logic [2:0] {
        VAR_1K  = 3'h0,
        VAR_2K  = 3'h1,
        VAR_4K  = 3'h2,
        VAR_8K  = 3'h3,
        VAR_16K = 3'h4
    } sebs_variant_t;

    typedef enum logic [2:0] {
        DS_IDLE  = 3'h0,
        DS_DSEL  = 3'h1,
        DS_ADDR  = 3'h3,
        DS_WDATA = 3'h2,
        DS_RDATA = 3'h6,
        DS_PROG  = 3'h7
    } sebs_dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'h0,
        HS_START = 2'h1,
        HS_BYTE  = 2'h3,
        HS_STOP  = 2'h2
    } sebs_host_state_t;

    // Host register offsets and command field
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] CMD_START = 2'h0;
    localparam logic [1:0] CMD_STOP = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    localparam int unsigned CMD_ACK_BIT = 2;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_ACK_BIT = 1;
endpackage

// ===== serial_eeprom_bus_slave_select_tb.sv
// Testbench: host and memory ends joined by the link, run via registers.
// Assumes package timings; programming count shortened for short runs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module serial_eeprom_bus_slave_select_tb;
    import sebs_pkg::*;
    localparam int unsigned PCYC = 20;
    logic       ref_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [1:0] reg_addr  = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] cs_pins   = 3'h0;
    logic       inhibit   = 1'b0;
    logic       sup_rst   = 1'b0;
    logic       prog_busy;
    int         n_fail    = 0;
    int         tests_run = 0;
    int         prog_cnt  = 0;
    logic [2:0] cs;
    logic [7:0] a;
    logic [7:0] d [3];
    always #10 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) if (prog_busy === 1'b1) prog_cnt++;
    sebs_link_if link ();
    sebs_host sebs_host_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link(link), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
    sebs_device #(.VARIANT(VAR_1K), .PROG_CYC_P(PCYC)) sebs_device_i (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(link),
        .chip_select_pins_i(cs_pins), .write_inhibit_pin_i(inhibit),
        .supply_reset_i(sup_rst), .prog_busy_o(prog_busy));
    sebs_link_chk sebs_link_chk_i (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .host_scl_o(link.host_scl_o),
        .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    function automatic logic [7:0] sel(input logic [2:0] c, input logic r);
        return {SEL_TYPE_CODE, c, r};
    endfunction
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic reg_wr_t(input logic [1:0] ad, input logic [7:0] wd);
        @(posedge ref_clk_i);
        reg_addr  <= ad;
        reg_wdata <= wd;
        reg_wr    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_rd_t(input logic [1:0] ad, output logic [7:0] rd);
        @(posedge ref_clk_i);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd <= 1'b0;
        // Data stand only in this cycle; take them mid-cycle
        @(negedge ref_clk_i);
        rd = reg_rdata;
        @(posedge ref_clk_i);
    endtask
    // Commands to a busy host are dropped, so poll before the next one
    task automatic issue(input logic [7:0] c, output logic [7:0] st);
        reg_wr_t(REG_CMD, c);
        repeat (4) @(posedge ref_clk_i);
        for (int i = 0; i < 8000; i++) begin
            reg_rd_t(REG_STATUS, st);
            if (st[STAT_BUSY_BIT] === 1'b0) break;
        end
        `CHK("busy", 1'b0, st[STAT_BUSY_BIT])
    endtask
    task automatic cond(input logic [1:0] c);
        logic [7:0] st;
        issue({6'h00, c}, st);
    endtask
    task automatic wbyte(input logic [7:0] b, input logic ea);
        logic [7:0] st;
        reg_wr_t(REG_DATA, b);
        issue({6'h00, CMD_WRITE}, st);
        `CHK("ack", ea, st[STAT_ACK_BIT])
    endtask
    task automatic rbyte(input logic more, input logic [7:0] eb);
        logic [7:0] st;
        logic [7:0] got;
        issue({5'h00, more, CMD_READ}, st);
        reg_rd_t(REG_DATA, got);
        `CHK("rdata", eb, got)
    endtask
    initial begin
        repeat (95000) @(posedge ref_clk_i);
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(83));
        cs = 3'($urandom);
        a  = 8'($urandom_range(0, 252));
        foreach (d[k]) d[k] = 8'($urandom);
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        cs_pins   <= cs;
        cond(CMD_START);
        wbyte(sel(~cs, 1'b0), 1'b0);
        cond(CMD_STOP);
        cond(CMD_START);
        wbyte(sel(cs, 1'b0), 1'b1);
        wbyte(a, 1'b1);
        foreach (d[k]) wbyte(d[k], 1'b1);
        prog_cnt = 0;
        cond(CMD_STOP);
        repeat (50) @(posedge ref_clk_i);
        `CHK("prog", PCYC, prog_cnt)
        inhibit <= 1'b1;
        cond(CMD_START);
        wbyte(sel(cs, 1'b0), 1'b1);
        wbyte(a, 1'b1);
        prog_cnt = 0;
        wbyte(~d[0], 1'b0);
        cond(CMD_STOP);
        repeat (50) @(posedge ref_clk_i);
        `CHK("prog", 0, prog_cnt)
        inhibit <= 1'b0;
        cs = cs ^ 3'h3;
        cs_pins <= cs;
        repeat (5) @(posedge ref_clk_i);
        cond(CMD_START);
        wbyte(sel(cs, 1'b0), 1'b1);
        wbyte(a, 1'b1);
        cond(CMD_START);
        wbyte(sel(cs, 1'b1), 1'b1);
        rbyte(1'b1, d[0]);
        rbyte(1'b0, d[1]);
        cond(CMD_STOP);
        cond(CMD_START);
        wbyte(sel(cs, 1'b1), 1'b1);
        rbyte(1'b0, d[2]);
        cond(CMD_STOP);
        sup_rst <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        cond(CMD_START);
        wbyte(sel(cs, 1'b1), 1'b0);
        cond(CMD_STOP);
        sup_rst <= 1'b0;
        close_out();
    end
endmodule // serial_eeprom_bus_slave_select_tb
`default_nettype wire
